/* File: hw/base_timer_defines.vh */
// Constants for the base timer and waveform output control block.
// Included by the timer module; holds definitions only.
`ifndef BASE_TIMER_DEFINES_VH
`define BASE_TIMER_DEFINES_VH

// Count clock select codes
`define CLK_SEL_STOP 2'h0
`define CLK_SEL_PULSE 2'h2
`define CLK_SEL_F1 2'h3

// Count direction modes
`define DIR_UP 2'h0
`define DIR_UP_DOWN 2'h1
`define DIR_TWO_PHASE 2'h2

// Prescale divisor value meaning no division
`define DIV_NONE 5'h1F

// Output mode code that routes channel 0/1 to the serial pins
`define MODE_SERIAL 3'h7
// Set/reset output mode code
`define MODE_SET_RESET 3'h2

// Waveform output control field positions
`define WOC_MODE_LSB 0
`define WOC_MODE_MSB 2
`define WOC_INV_BIT 4
`define WOC_IVL_BIT 5
`define WOC_RESTART_BIT 6

// Timer values and waveform output control register reset value
`define TIMER_ZERO 16'h0000
`define TIMER_MAX 16'hFFFF
`define WOC_RESET 8'h00

`endif

/* File: hw/base_timer_waveform.v */
// Base timer with prescaler and three counting modes, plus waveform
// output control for eight channels. Control bits arrive as plain ports
// from the register logic on clk; quadrature inputs come from pins.
`timescale 1ns/10ps
`default_nettype none
`include "base_timer_defines.vh"

module base_timer_waveform (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Timer control
  input wire timer_run,
  input wire [1:0] count_clock_select,
  input wire [1:0] count_direction_mode,
  input wire [4:0] prescale_divisor,
  // Timer value write
  input wire timer_write,
  input wire [15:0] timer_write_data,
  // Quadrature pins
  input wire phase_a_pin,
  input wire phase_b_pin,
  // Channel control
  input wire [7:0] channel_function_select,
  input wire [7:0] channel_function_enable,
  input wire [7:0] woc_write,
  input wire [63:0] woc_write_data,
  // Waveform levels from the compare logic, one per channel
  input wire [7:0] wave_level,
  // Serial function levels
  input wire serial_tx_level,
  input wire serial_clock_level,
  // Status
  output reg [15:0] timer_value_q,
  output reg [63:0] woc_readback_q,
  output reg restart_enable_q,
  // Pins
  output reg [7:0] channel_out_q,
  output reg [7:0] channel_oe_q,
  output reg serial_tx_pin_1,
  output reg serial_clock_pin_1,
  output reg serial_clock_oe_q
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  reg [1:0] a_sync_q;
  reg [1:0] b_sync_q;
  reg a_last_q;
  reg b_last_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      a_sync_q <= 2'h0;
      b_sync_q <= 2'h0;
      a_last_q <= 1'b0;
      b_last_q <= 1'b0;
    end else begin
      a_sync_q <= {a_sync_q[0], phase_a_pin};
      b_sync_q <= {b_sync_q[0], phase_b_pin};
      a_last_q <= a_sync_q[1];
      b_last_q <= b_sync_q[1];
    end
  end

  wire a_edge = a_sync_q[1] ^ a_last_q;
  wire b_edge = b_sync_q[1] ^ b_last_q;
  wire qd_edge = a_edge | b_edge;
  // A leads B: after an A edge, A differs from B; after a B edge, they match
  wire qd_up = (a_edge & (a_sync_q[1] != b_sync_q[1])) |
    (b_edge & (a_sync_q[1] == b_sync_q[1]));

  ////////////////////////////////////////////////////////////////////////
  // Prescaler

  reg [5:0] pre_cnt_q;
  reg pre_half_q;
  wire src_pulse = (count_direction_mode == `DIR_TWO_PHASE) ? qd_edge : 1'b1;
  wire clk_run = (count_clock_select != `CLK_SEL_STOP);
  wire [5:0] pre_top = {1'b0, prescale_divisor};
  reg tick;

  always @* begin
    if (prescale_divisor == `DIV_NONE) begin
      tick = clk_run & src_pulse;
    end else begin
      tick = clk_run & src_pulse & pre_half_q & (pre_cnt_q >= pre_top);
    end
  end

  // Divide by 2(n+1): two half periods of n+1 source pulses each
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt_q <= 6'h00;
      pre_half_q <= 1'b0;
    end else if (!timer_run || !clk_run) begin
      pre_cnt_q <= 6'h00;
      pre_half_q <= 1'b0;
    end else if (src_pulse) begin
      if (pre_cnt_q >= pre_top) begin
        pre_cnt_q <= 6'h00;
        pre_half_q <= ~pre_half_q;
      end else begin
        pre_cnt_q <= pre_cnt_q + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Base timer

  reg down_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_value_q <= `TIMER_ZERO;
      down_q <= 1'b0;
    end else if (!timer_run) begin
      timer_value_q <= `TIMER_ZERO;
      down_q <= 1'b0;
    end else if (timer_write) begin
      timer_value_q <= timer_write_data;
    end else if (tick) begin
      case (count_direction_mode)
        `DIR_UP: begin
          timer_value_q <= timer_value_q + 16'h0001;
        end
        `DIR_UP_DOWN: begin
          if (!down_q && timer_value_q == `TIMER_MAX) begin
            down_q <= 1'b1;
            timer_value_q <= timer_value_q - 16'h0001;
          end else if (down_q && timer_value_q == `TIMER_ZERO) begin
            down_q <= 1'b0;
            timer_value_q <= timer_value_q + 16'h0001;
          end else if (down_q) begin
            timer_value_q <= timer_value_q - 16'h0001;
          end else begin
            timer_value_q <= timer_value_q + 16'h0001;
          end
        end
        `DIR_TWO_PHASE: begin
          if (qd_up) begin
            timer_value_q <= timer_value_q + 16'h0001;
          end else begin
            timer_value_q <= timer_value_q - 16'h0001;
          end
        end
        default: begin
          timer_value_q <= timer_value_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Waveform output control registers and output stage

  genvar ch;
  generate
    for (ch = 0; ch < 8; ch = ch + 1) begin : chan
      wire [7:0] wdata = woc_write_data[ch*8 +: 8];
      wire [2:0] mode = woc_readback_q[ch*8 + `WOC_MODE_MSB -: 3];
      wire invert_output_enable = woc_readback_q[ch*8 + `WOC_INV_BIT];
      wire inverted_default_level = woc_readback_q[ch*8 + `WOC_IVL_BIT];
      wire active = ~channel_function_select[ch] & channel_function_enable[ch];
      // Odd channel paired with an even channel in set/reset mode
      wire odd_locked;
      wire odd_silent;
      if (ch % 2 == 1) begin : odd
        assign odd_locked = (woc_readback_q[(ch-1)*8 + `WOC_MODE_MSB -: 3] == `MODE_SET_RESET);
        assign odd_silent = odd_locked;
      end else begin : even
        assign odd_locked = 1'b0;
        assign odd_silent = 1'b0;
      end
      wire serial = (ch < 2) && (mode == `MODE_SERIAL);
      // Inversion last: with the default level bit clear, level 0 gives high, level 1 gives low; with it set, level 0 gives low
      wire raw = invert_output_enable ? ~(wave_level[ch] ^ inverted_default_level) : wave_level[ch];

      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          woc_readback_q[ch*8 +: 8] <= `WOC_RESET;
          channel_out_q[ch] <= 1'b0;
          channel_oe_q[ch] <= 1'b0;
        end else begin
          if (woc_write[ch] && !odd_locked) begin
            if (ch == 0) begin
              woc_readback_q[ch*8 +: 8] <= wdata;
            end else begin
              woc_readback_q[ch*8 +: 8] <= wdata & 8'hBF;
            end
          end
          channel_out_q[ch] <= raw;
          channel_oe_q[ch] <= active & ~odd_silent & ~serial;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Serial pin routing and restart flag

  wire tx_route = woc_readback_q[`WOC_MODE_MSB -: 3] == `MODE_SERIAL;
  wire sck_route = woc_readback_q[8 + `WOC_MODE_MSB -: 3] == `MODE_SERIAL;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_tx_pin_1 <= 1'b1;
      serial_clock_pin_1 <= 1'b1;
      serial_clock_oe_q <= 1'b0;
      restart_enable_q <= 1'b0;
    end else begin
      serial_tx_pin_1 <= tx_route ? serial_tx_level : 1'b1;
      serial_clock_pin_1 <= sck_route ? serial_clock_level : 1'b1;
      serial_clock_oe_q <= sck_route;
      restart_enable_q <= woc_readback_q[`WOC_RESTART_BIT];
    end
  end

endmodule // base_timer_waveform
`default_nettype wire

/* File: test/base_timer_props.sv */
// Port checker for the base timer block.
// Assumes one clock and the design's own port names.
`timescale 1ns/10ps
`default_nettype none
module base_timer_checker (
  // Clock, reset, controls
  input wire logic clk, reset_n, timer_run, timer_write,
  input wire logic [1:0] count_clock_select, count_direction_mode,
  input wire logic [4:0] prescale_divisor,
  input wire logic [7:0] woc_write, channel_oe_q,
  // Results
  input wire logic [15:0] timer_value_q,
  input wire logic [63:0] woc_readback_q,
  input wire logic serial_tx_pin_1, serial_clock_oe_q, restart_enable_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_hold; !timer_run |=> timer_value_q == 16'h0000; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_stop; timer_run && count_clock_select == 2'h0 && !timer_write
    |=> $stable(timer_value_q); endproperty
  a_stop: assert property (p_stop) else $error("stop");
  property p_up; timer_run && $past(timer_run) && count_clock_select == 2'h3 && !timer_write
    && prescale_divisor == 5'h1F && count_direction_mode == 2'h0
    |=> timer_value_q == $past(timer_value_q) + 16'h0001; endproperty
  a_up: assert property (p_up) else $error("up");
  property p_restart; woc_write[1] |=> !woc_readback_q[14]; endproperty
  a_restart: assert property (p_restart) else $error("restart");
  property p_sclk; woc_readback_q[10:8] == 3'h7 |=> serial_clock_oe_q; endproperty
  a_sclk: assert property (p_sclk) else $error("sclk");
  property p_tx; woc_readback_q[2:0] != 3'h7 |=> serial_tx_pin_1; endproperty
  a_tx: assert property (p_tx) else $error("tx");
  property p_odd_oe; woc_readback_q[2:0] == 3'h2 |=> !channel_oe_q[1]; endproperty
  a_odd_oe: assert property (p_odd_oe) else $error("odd oe");
  property p_odd_wr; woc_readback_q[2:0] == 3'h2 && woc_write == 8'h02
    |=> $stable(woc_readback_q[15:8]); endproperty
  a_odd_wr: assert property (p_odd_wr) else $error("odd write");
  property p_restart_ch0; 1'b1 |=> restart_enable_q == $past(woc_readback_q[6]); endproperty
  a_restart_ch0: assert property (p_restart_ch0) else $error("restart ch0");
endmodule // base_timer_checker
bind base_timer_waveform base_timer_checker checker_inst (.*);
`default_nettype wire

/* File: test/quad_source.sv */
// Quadrature pin source standing in for an external encoder.
// Assumes step is a one-cycle request sampled on the rising edge.
`timescale 1ns/10ps
`default_nettype none
module quad_source (
  // Clock, reset, request
  input wire logic clk,
  input wire logic reset_n,
  input wire logic step,
  input wire logic up,
  // Encoder pins
  output logic phase_a_pin,
  output logic phase_b_pin
);
  logic [1:0] phase_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      phase_q <= 2'h0;
    else if (step)
      phase_q <= up ? phase_q + 2'h1 : phase_q - 2'h1;
  end
  // Gray order, A leads B going up
  assign phase_a_pin = phase_q == 2'h1 || phase_q == 2'h2;
  assign phase_b_pin = phase_q[1];
endmodule // quad_source
`default_nettype wire

/* File: test/testbench.sv */
// Testbench for the base timer block.
// Assumes the checker bind and the quadrature source.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 0, reset_n = 0, timer_run = 0, timer_write = 0, step = 0, up = 1;
  logic phase_a_pin, phase_b_pin, serial_tx_level = 0, serial_clock_level = 0;
  logic [1:0] count_clock_select = 0, count_direction_mode = 0;
  logic [4:0] prescale_divisor = 5'h1F;
  logic [15:0] timer_write_data = 16'hFFFD, v, timer_value_q;
  logic [7:0] channel_function_select = 0, channel_function_enable = 8'hFF, woc_write = 0;
  logic [7:0] wave_level = 0, channel_out_q, channel_oe_q;
  logic [63:0] woc_write_data = 0, woc_readback_q;
  logic restart_enable_q, serial_tx_pin_1, serial_clock_pin_1, serial_clock_oe_q;
  int n_errors = 0, comparisons = 0;
  always #10 clk = ~clk;
  base_timer_waveform uut (.*);
  quad_source partner (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic woc(input int ch, input logic [7:0] d);
    woc_write_data[ch*8 +: 8] = d;
    woc_write[ch] = 1'h1;
    cyc(1);
    woc_write = 8'h00;
    cyc(2);
  endtask
  task automatic tmr(input logic [1:0] s, input logic [1:0] m);
    timer_run = 1'h1;
    count_clock_select = s;
    count_direction_mode = m;
    prescale_divisor = 5'h1F;
  endtask
  task automatic steps(input logic u, input int n);
    up = u;
    repeat (n) begin
      step = 1'h1;
      cyc(1);
      step = 1'h0;
      cyc(3);
    end
    cyc(4);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_errors++;
    test_done;
  end
  initial begin
    cyc(8);
    reset_n = 1'h1;
    cyc(2);
    chk("held", 16'h0000, timer_value_q);
    tmr(2'h3, 2'h0);
    cyc(2);
    v = timer_value_q;
    cyc(10);
    chk("up", v + 16'h000A, timer_value_q);
    prescale_divisor = 5'h00;
    cyc(2);
    v = timer_value_q;
    cyc(20);
    chk("div2", v + 16'h000A, timer_value_q);
    count_clock_select = 2'h0;
    cyc(1);
    v = timer_value_q;
    cyc(10);
    chk("stop", v, timer_value_q);
    tmr(2'h3, 2'h1);
    timer_write = 1'h1;
    cyc(1);
    timer_write = 1'h0;
    cyc(6);
    chk("turn", 16'hFFFB, timer_value_q);
    timer_run = 1'h0;
    cyc(2);
    chk("run off", 16'h0000, timer_value_q);
    $display("count test done");
    tmr(2'h2, 2'h2);
    cyc(2);
    steps(1, 8);
    chk("quad up", 16'h0008, timer_value_q);
    steps(0, 3);
    chk("quad down", 16'h0005, timer_value_q);
    $display("two phase test done");
    tmr(2'h3, 2'h0);
    woc(0, 8'h47);
    chk("restart", 1, restart_enable_q);
    chk("tx", 0, serial_tx_pin_1);
    woc(1, 8'h07);
    chk("ch1", 8'h07, woc_readback_q[15:8]);
    chk("sclk", 2'h2, {serial_clock_oe_q, serial_clock_pin_1});
    woc(0, 8'h02);
    chk("restart off", 0, restart_enable_q);
    woc(1, 8'h05);
    chk("odd write", 8'h07, woc_readback_q[15:8]);
    chk("oe", 2'h1, channel_oe_q[1:0]);
    woc(2, 8'h10);
    chk("inv 0", 1, channel_out_q[2]);
    wave_level = 8'h04;
    cyc(1);
    chk("inv wave", 0, channel_out_q[2]);
    wave_level = 8'h00;
    woc(2, 8'h30);
    chk("inv 1", 0, channel_out_q[2]);
    woc(2, 8'h06);
    chk("ch2", 8'h06, woc_readback_q[23:16]);
    $display("control test done");
    test_done;
  end
endmodule // testbench
`default_nettype wire
